// File: rtl/host_port_defs.svh
/*
  Offsets, field positions, reset values and timing counts for the
  two-channel host bus port. Assumes a 40 MHz system clock.
*/
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (3-bit register address)
// ----------------------------------------------------------------
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_FIFO_CTRL 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SPR 3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FIFO_CTRL_EN 0
`define FIFO_CTRL_DMA 3
`define LCR_DLAB 7
`define IER_RX 0
`define IER_TX 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DLL_RST 8'h01
`define DIV_HIGH_RST 8'h00
`define LCR_RST 8'h00
`define ZERO8 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define RESET_MIN_NS 40
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/host_port_pkg.sv
/*
  Types for the two-channel host bus port.
  Assumes the defs header is compiled alongside.
*/
`default_nettype none
package host_port_pkg;
  // Bus-side strobes after mode decode
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [2:0] addr;
    logic [7:0] data;
  } bus_req_t;

  // Per-channel programmable state
  typedef struct packed {
    logic [7:0] ier;
    logic [7:0] fifo_ctrl;
    logic [7:0] lcr;
    logic [7:0] mcr;
    logic [7:0] spr;
    logic [7:0] dll;
    logic [7:0] div_high;
  } chan_regs_t;

  // Access phase of the bus
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } bus_state_t;
endpackage
`default_nettype wire

// File: rtl/dual_uart_host_bus_port.sv
/*
  Host bus front end of a two-channel UART: bus decode in both styles,
  channel registers, id readout, interrupt pin and oscillator copy.
  Assumes host pins synchronous to clk_sys, held over several clocks.
*/
// Implementation choices: the register offsets and the strobed register port.
// Functional notes
// - Eight data bits, three address lines
// - Transfers timed only by select and strobes
// - Reset returns both channels to defaults
// - Zero divisors read back id and revision
// - Style pin high: separate active-low selects
// - Both selects low: write both channels
// - Style pin low: shared select, address picks
// - Channel address bit ignored in strobe style
// - Strobe pair versus single read/write line
// - Legacy DMA bit has no effect
// - Transmit interrupt from holding state
// - Receive interrupt from data presence
// - Interrupt polarity follows bus style
// - Oscillator drives baud clocks, buffered out
`include "host_port_defs.svh"
`default_nettype none
module dual_uart_host_bus_port
  import host_port_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h3C,  // Arbitrary value
  parameter int DATA_W = 8
)
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Bus style and selects
  input wire logic bus_style_strobe,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic shared_select_n,
  input wire logic channel_choose_addr,
  // Strobes
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic rw_line,
  // Address and data
  input wire logic [2:0] reg_addr,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Channel status from the serial cores
  input wire logic [1:0] tx_holding_full,
  input wire logic [1:0] tx_fifo_above_trig,
  input wire logic [1:0] rx_data_present,
  input wire logic [1:0] rx_fifo_above_trig,
  // Interrupt pins, one per channel
  output logic [1:0] irq_pin,
  // Oscillator
  input wire logic osc_input,
  output logic osc_buffered_out,
  output logic [1:0] baud_clk_src
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 8)
  begin : g_chk
    $error("Data bus must be eight bits wide");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  bus_req_t req; // Decoded request, combinational

  // Decode selects and direction per style
  always_comb
  begin
    req.addr = reg_addr;
    req.data = data_in;
    if (bus_style_strobe)
    begin
      // Separate selects, address bit ignored
      req.sel = {~chan_b_select_n, ~chan_a_select_n};
      req.rd = ~read_strobe_n & (|req.sel);
      req.wr = ~write_strobe_n & (|req.sel);
    end
    else
    begin
      // Shared select, address bit picks channel
      req.sel = shared_select_n ? 2'h0 :
        (channel_choose_addr ? 2'h2 : 2'h1);
      req.rd = ~shared_select_n & rw_line;
      req.wr = ~shared_select_n & ~rw_line;
    end
  end

  // ----------------------------------------------------------------
  // Access phase: one action per strobe, not per clock
  // ----------------------------------------------------------------
  bus_state_t state_reg, state_next;
  logic wr_fire; // Write commit pulse
  logic rd_fire; // Read capture pulse

  // Next phase; acts on strobe edge so a long strobe writes once
  always_comb
  begin
    state_next = state_reg;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (req.wr)
        begin
          state_next = ST_WRITE;
          wr_fire = 1'b1;
        end
        else if (req.rd)
        begin
          state_next = ST_READ;
          rd_fire = 1'b1;
        end
      end
      ST_READ:
        if (!req.rd)
          state_next = ST_IDLE;
      ST_WRITE:
        if (!req.wr)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Phase register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  chan_regs_t regs_reg [2];
  chan_regs_t regs_next [2];

  // Reset image of one channel
  function automatic chan_regs_t reset_image();
    chan_regs_t r;
    r.ier = `ZERO8;
    r.fifo_ctrl = `ZERO8;
    r.lcr = `LCR_RST;
    r.mcr = `ZERO8;
    r.spr = `ZERO8;
    r.dll = `DLL_RST;
    r.div_high = `DIV_HIGH_RST;
    return r;
  endfunction

  // Writes land only in selected channels, both when both selected
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      regs_next[c] = regs_reg[c];
      if (wr_fire && req.sel[c])
      begin
        unique case (req.addr)
          `OFS_DATA:
            if (regs_reg[c].lcr[`LCR_DLAB])
              regs_next[c].dll = req.data;
          `OFS_IER:
            if (regs_reg[c].lcr[`LCR_DLAB])
              regs_next[c].div_high = req.data;
            else
              regs_next[c].ier = req.data;
          // DMA bit stored but never read by logic
          `OFS_FIFO_CTRL: regs_next[c].fifo_ctrl = req.data;
          `OFS_LCR: regs_next[c].lcr = req.data;
          `OFS_MCR: regs_next[c].mcr = req.data;
          `OFS_SPR: regs_next[c].spr = req.data;
          default: ; // Status offsets are read-only
        endcase
      end
    end
  end

  // Register both channels
  always_ff @(posedge clk_sys)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (reset)
        regs_reg[c] <= reset_image();
      else
        regs_reg[c] <= regs_next[c];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_data_next;
  logic [7:0] data_out_reg;
  logic rd_chan; // Channel that answers a read

  // Read mux; a dual-select read is illegal, channel A answers
  function automatic logic [7:0] read_word(input chan_regs_t r,
                                           input logic [2:0] a,
                                           input logic [1:0] st);
    logic zero_div;
    zero_div = (r.dll == `ZERO8) && (r.div_high == `ZERO8);
    read_word = `ZERO8;
    unique case (a)
      `OFS_DATA:
        if (r.lcr[`LCR_DLAB])
          read_word = zero_div ? REVISION : r.dll;
      `OFS_IER:
        if (r.lcr[`LCR_DLAB])
          read_word = zero_div ? DEVICE_ID : r.div_high;
        else
          read_word = r.ier;
      `OFS_FIFO_CTRL: read_word = {6'h00, st};
      `OFS_LCR: read_word = r.lcr;
      `OFS_MCR: read_word = r.mcr;
      `OFS_LSR: read_word = {1'b0, ~st[1], ~st[1], 4'h0, st[0]};
      `OFS_MSR: read_word = `ZERO8;
      `OFS_SPR: read_word = r.spr;
      default: read_word = `ZERO8;
    endcase
  endfunction

  // Capture answer at the read strobe, hold it while strobed
  always_comb
  begin
    rd_chan = req.sel[0] ? 1'b0 : 1'b1;
    rd_data_next = data_out_reg;
    if (rd_fire)
      rd_data_next = read_word(regs_reg[rd_chan], req.addr,
        {tx_holding_full[rd_chan], rx_data_present[rd_chan]});
  end

  // Read data register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      data_out_reg <= `ZERO8;
    else
      data_out_reg <= rd_data_next;
  end

  assign data_out = data_out_reg;
  assign data_oe = (state_reg == ST_READ) && req.rd;

  // ----------------------------------------------------------------
  // Interrupt pins
  // ----------------------------------------------------------------
  logic [1:0] irq_next;
  logic [1:0] irq_reg;
  logic [1:0] tx_cond; // Transmit wants service
  logic [1:0] rx_cond; // Receive wants service

  // Service conditions per channel, then style polarity
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (regs_reg[c].fifo_ctrl[`FIFO_CTRL_EN])
      begin
        tx_cond[c] = ~tx_fifo_above_trig[c];
        rx_cond[c] = rx_fifo_above_trig[c];
      end
      else
      begin
        tx_cond[c] = ~tx_holding_full[c];
        rx_cond[c] = rx_data_present[c];
      end
      irq_next[c] = (tx_cond[c] & regs_reg[c].ier[`IER_TX]) |
                    (rx_cond[c] & regs_reg[c].ier[`IER_RX]);
      // Active high in strobe style, active low otherwise
      irq_next[c] = bus_style_strobe ? irq_next[c] : ~irq_next[c];
    end
  end

  // Interrupt pin register; reset clears both pins low in either style, idle level then follows style
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irq_reg <= 2'h0;
    else
      irq_reg <= irq_next;
  end

  assign irq_pin = irq_reg;

  // ----------------------------------------------------------------
  // Oscillator copy; a clock path, not a register
  // ----------------------------------------------------------------
  assign osc_buffered_out = osc_input;
  assign baud_clk_src = {osc_input, osc_input};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_write_a;
    wr_fire && req.sel == 2'h1 && req.addr == `OFS_SPR;
  endsequence

  a_write_single: assert property (
    s_write_a |=> regs_reg[0].spr == $past(req.data) &&
      $stable(regs_reg[1].spr))
    else $error("Single-select write leaked to channel B");

  a_write_both: assert property (
    wr_fire && req.sel == 2'h3 && req.addr == `OFS_SPR |=>
      regs_reg[0].spr == regs_reg[1].spr)
    else $error("Dual-select write not applied to both");

  a_style_addr: assert property (
    bus_style_strobe |-> req.sel == {~chan_b_select_n, ~chan_a_select_n})
    else $error("Channel address bit used in strobe style");

  a_shared_sel: assert property (
    !bus_style_strobe && !shared_select_n |->
      req.sel == (channel_choose_addr ? 2'h2 : 2'h1))
    else $error("Shared select decoded wrong channel");

  a_one_write: assert property (
    wr_fire |=> !wr_fire [*1])
    else $error("Held write strobe wrote twice");

  a_id_read: assert property (
    rd_fire && req.sel == 2'h1 && req.addr == `OFS_IER &&
      regs_reg[0].lcr[`LCR_DLAB] && regs_reg[0].dll == `ZERO8 &&
      regs_reg[0].div_high == `ZERO8 |=> data_out == DEVICE_ID)
    else $error("Zero divisor read did not give id");

  a_irq_pol: assert property (
    ##1 $stable(bus_style_strobe) && !bus_style_strobe &&
      regs_reg[0].ier == `ZERO8 && $past(regs_reg[0].ier) == `ZERO8
      |-> irq_pin[0])
    else $error("Idle interrupt not high in shared style");

  a_rx_irq: assert property (
    bus_style_strobe && regs_reg[0].ier[`IER_RX] &&
      !regs_reg[0].fifo_ctrl[`FIFO_CTRL_EN] && rx_data_present[0] |=>
      irq_pin[0] || !bus_style_strobe)
    else $error("Receive data did not raise interrupt");

  a_reset_div: assert property (
    disable iff (1'b0) reset |=> regs_reg[1].dll == `DLL_RST)
    else $error("Divisor not at default after reset");

endmodule
`default_nettype wire

// File: test/host_cpu_model.sv
/*
  Host processor model for the two-channel host bus port.
  Assumes the bench gives it the bus style level and calls xfer.
*/
`default_nettype none
module host_cpu_model
  import host_port_pkg::*;
(
  // Clock and style
  input wire logic clk_sys,
  input wire logic bus_style_strobe,
  // Selects and strobes toward the port
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  output logic shared_select_n,
  output logic channel_choose_addr,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic rw_line,
  // Address and data
  output logic [2:0] reg_addr,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: everything deselected
  initial
  begin
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    shared_select_n = 1'b1;
    channel_choose_addr = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    rw_line = 1'b1;
    reg_addr = 3'h0;
    data_in = 8'h00;
  end

  // One bus cycle; sel bit0 is channel A, bit1 channel B
  task automatic xfer(input logic rd, input logic [1:0] sel,
                      input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    // Never read both channels at once
    if (rd && (sel == 2'h3))
      sel = 2'h1;
    @(posedge clk_sys);
    reg_addr <= a;
    data_in <= d;
    if (bus_style_strobe)
    begin
      // Separate selects; channel address driven wrong on purpose
      chan_a_select_n <= ~sel[0];
      chan_b_select_n <= ~sel[1];
      channel_choose_addr <= sel[0];
      read_strobe_n <= ~rd;
      write_strobe_n <= rd;
    end
    else
    begin
      // Shared select, address bit picks the channel
      shared_select_n <= 1'b0;
      channel_choose_addr <= sel[1];
      rw_line <= rd;
    end
    // Capture edge, then answer edge
    repeat (2) @(posedge clk_sys);
    #1 q = data_out;
    @(posedge clk_sys);
    // Release; stale lines flip so no old value lingers
    chan_a_select_n <= 1'b1;
    chan_b_select_n <= 1'b1;
    shared_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    rw_line <= 1'b1;
    data_in <= ~d;
    reg_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
/*
  Self-checking bench for the two-channel host bus port.
  Assumes the host model and the design package are compiled first.
*/
`default_nettype none
`define CHECK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("mismatch %s exp %h got %h", nm, exp, got); \
    end \
  end
module testbench
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [7:0] ID_CODE = 8'hA7; // Arbitrary value
  localparam logic [7:0] REV_CODE = 8'h1D; // Arbitrary value
  logic clk_sys;
  logic reset;
  logic bus_style_strobe;
  logic csa_n, csb_n, cs_n, choose, rd_n, wr_n, rw;
  logic [2:0] reg_addr;
  logic [7:0] data_in, data_out;
  logic data_oe;
  logic [1:0] tx_full, tx_trig, rx_pres, rx_trig, irq_pin, baud_src;
  logic osc_input, osc_out;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [7:0] q;
  int n_oe = 0; // Edges with the read drive on
  int n_rd = 0; // Reads issued

  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  dual_uart_host_bus_port #(.DEVICE_ID(ID_CODE), .REVISION(REV_CODE))
    dual_uart_host_bus_port_inst (.clk_sys(clk_sys), .reset(reset),
    .bus_style_strobe(bus_style_strobe), .chan_a_select_n(csa_n),
    .chan_b_select_n(csb_n), .shared_select_n(cs_n),
    .channel_choose_addr(choose), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .rw_line(rw), .reg_addr(reg_addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .tx_holding_full(tx_full), .tx_fifo_above_trig(tx_trig),
    .rx_data_present(rx_pres), .rx_fifo_above_trig(rx_trig),
    .irq_pin(irq_pin), .osc_input(osc_input),
    .osc_buffered_out(osc_out), .baud_clk_src(baud_src));
  host_cpu_model host_cpu_model_inst (.clk_sys(clk_sys),
    .bus_style_strobe(bus_style_strobe), .chan_a_select_n(csa_n),
    .chan_b_select_n(csb_n), .shared_select_n(cs_n),
    .channel_choose_addr(choose), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .rw_line(rw), .reg_addr(reg_addr),
    .data_in(data_in), .data_out(data_out));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Write one register of the selected channels
  task automatic wr(input logic [1:0] s, input logic [2:0] a,
                    input logic [7:0] d);
    host_cpu_model_inst.xfer(1'b0, s, a, d, q);
  endtask

  // Read one register and compare
  task automatic rd(input logic [1:0] s, input logic [2:0] a,
                    input logic [7:0] e);
    n_rd++;
    host_cpu_model_inst.xfer(1'b1, s, a, 8'h00, q);
    `CHECK("read data", e, q)
  endtask

  // Interrupt pins are registered: let them settle first
  task automatic chk_irq(input logic [1:0] e);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHECK("irq_pin", e, irq_pin)
    // Back on a rising edge so the next stimulus lands there
    @(posedge clk_sys);
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // A hang counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  // Read drive edges; the model holds a strobe two edges past capture
  always @(posedge clk_sys)
  begin
    if (data_oe === 1'b1)
      n_oe++;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    bus_style_strobe = 1'b1;
    {tx_full, tx_trig, rx_pres, rx_trig} = 8'h00;
    osc_input = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    // Divisor defaults after reset, through the latch access bit
    wr(2'h3, 3'h3, 8'h80);
    rd(2'h1, 3'h0, 8'h01);
    rd(2'h1, 3'h1, 8'h00);
    // Zero divisors in both channels at once, then read codes
    wr(2'h3, 3'h0, 8'h00);
    wr(2'h3, 3'h1, 8'h00);
    wr(2'h2, 3'h3, 8'h80);
    rd(2'h1, 3'h1, ID_CODE);
    rd(2'h2, 3'h0, REV_CODE);
    // Separate register sets; stray channel address ignored
    wr(2'h3, 3'h3, 8'h00);
    wr(2'h1, 3'h7, 8'h11);
    wr(2'h2, 3'h7, 8'h22);
    rd(2'h1, 3'h7, 8'h11);
    rd(2'h2, 3'h7, 8'h22);
    wr(2'h3, 3'h7, 8'h33);
    rd(2'h2, 3'h7, 8'h33);
    // Channel A enables both sources, B stays quiet
    wr(2'h1, 3'h1, 8'h03);
    chk_irq(2'b01);
    tx_full <= 2'b11;
    chk_irq(2'b00);
    rx_pres <= 2'b11;
    chk_irq(2'b01);
    wr(2'h1, 3'h2, 8'h08);
    chk_irq(2'b01);
    // FIFO mode: transmit wants service below trigger, receive above
    wr(2'h1, 3'h2, 8'h09);
    tx_trig <= 2'b11;
    chk_irq(2'b00);
    rx_trig <= 2'b11;
    chk_irq(2'b01);
    // Read/write-line style: pin polarity flips
    bus_style_strobe <= 1'b0;
    chk_irq(2'b10);
    wr(2'h2, 3'h7, 8'h44);
    rd(2'h1, 3'h7, 8'h33);
    rd(2'h2, 3'h7, 8'h44);
    // Sources off: both active-low pins go idle high
    wr(2'h1, 3'h1, 8'h00);
    chk_irq(2'b11);
    // Reset in mid-run with the bus idle, shared style kept
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    chk_irq(2'b11);
    wr(2'h1, 3'h3, 8'h80);
    rd(2'h1, 3'h0, 8'h01);
    rd(2'h2, 3'h7, 8'h00);
    // Oscillator copies
    osc_input <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHECK("osc copy", 1'b1, osc_out)
    `CHECK("baud source", 2'b11, baud_src)
    // Two drive edges for every read that the model made
    `CHECK("data_oe cycles", 2 * n_rd, n_oe)
    summarize();
  end
endmodule
`default_nettype wire
